//--- rtl/rsc_regs.svh
// Purpose: Register map, field positions and timing constants for the
//          reset source controller.
// Assumes: 25 MHz system clock, 32-bit peripheral bus addresses.
// Notes:   Definitions only; include by bare name.
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// Register byte addresses
`define RSC_CFG_ADDR      32'h40005008
`define RSC_KEY_ADDR      32'h4000500C
`define RSC_STA_ADDR      32'h40005040

// Reset values and writable masks
`define RSC_CFG_RESET     16'h000F
`define RSC_CFG_WMASK     16'h000F
`define RSC_KEY_RESET     16'h0000
`define RSC_STA_WMASK     16'h000F
// Status after power-on: only the power-on flag set
`define RSC_STA_AFTER_POR 16'h0001
`define RSC_DATA_ZERO     16'h0000

// Configuration fields
`define RSC_CFG_ANALOG    3
`define RSC_CFG_PINS      0

// Status fields
`define RSC_STA_SOFT      3
`define RSC_STA_WDT       2
`define RSC_STA_PIN       1
`define RSC_STA_POR       0

// Unlock key words, in order
`define RSC_KEY_FIRST     16'h2009
`define RSC_KEY_SECOND    16'h0426

// Processor-side soft reset request (written by software, not here)
`define RSC_SYSRESET_ADDR 32'hE000ED0C
`define RSC_SYSRESET_WORD 32'h05FA0004

// Timing
`define RSC_CLK_NS        40
`define RSC_HOLD_NS       1000
`define RSC_HOLD_CYCLES   ((`RSC_HOLD_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_WDT_DEFAULT_S 32
`define RSC_NS_PER_S      1000000000
`define RSC_WDT_CYCLES    (`RSC_WDT_DEFAULT_S * (`RSC_NS_PER_S / `RSC_CLK_NS))

`endif

//--- rtl/rsc_pkg.sv
// Purpose: Types shared by the reset source controller files.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in rsc_regs.svh.
package rsc_pkg;
    // Key protection state
    typedef enum logic [1:0] {
        RSC_LOCKED,
        RSC_KEY_HALF,
        RSC_UNLOCKED
    } rsc_lock_e;

    // Register select from address decode
    typedef enum logic [1:0] {
        RSC_SEL_NONE,
        RSC_SEL_CFG,
        RSC_SEL_KEY,
        RSC_SEL_STA
    } rsc_sel_e;

    typedef logic [7:0]  rsc_count_t;
    typedef logic [15:0] rsc_word_t;
endpackage

//--- rtl/rsc_hold_timer.sv
// Purpose: Stretches a reset request into a minimum-length reset pulse.
// Assumes: start is synchronous to sys_clk.
// Notes:   Starts busy out of power-on so the power-on reset is stretched.
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_hold_timer (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic start,
    output logic      busy
);
    import rsc_pkg::*;

    rsc_count_t count_reg;   // Cycles left in the pulse
    rsc_count_t count_next;

    // Reload while the request stands, then count down to zero
    always_comb begin
        if (start) begin
            count_next = rsc_count_t'(`RSC_HOLD_CYCLES);
        end else if (count_reg != '0) begin
            count_next = count_reg - 8'h01;
        end else begin
            count_next = count_reg;
        end
    end

    // Power-on counts as a full reset, so start loaded
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= rsc_count_t'(`RSC_HOLD_CYCLES);
        end else begin
            count_reg <= count_next;
        end
    end

    assign busy = (count_reg != '0);
endmodule

//--- rtl/rsc_reset_ctrl.sv
// Purpose: Reset source controller: records the reset cause, holds the
//          key-protected retention settings and drives the reset fans.
// Assumes: reset_n is the power-on reset; other sources are synchronous.
// Notes:   Registers sit on the peripheral bus (APB3 signalling).
//
// Overview of operation
// - Four sources: pin, power-on, watchdog, software
// - Bit 3 zero keeps analog state
// - Bit 0 zero keeps pins, logic
// - Two fixed pins always reset
// - Two key words, then configuration write
// - Other register write relocks key
// - Status holds cause until software clears
// - Software reset sets status bit 3
// - Watchdog timeout sets status bit 2
// - Reset pin sets status bit 1
// - Power-on sets status bit 0
// - Power-on clears the status register, to bit 0 alone; other resets only set bits
// - Pin and power-on resets reset everything
// - Watchdog enabled with default timeout after reset
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_reset_ctrl #(
    parameter logic [31:0] WDT_DEFAULT_CYCLES = 32'(`RSC_WDT_CYCLES)
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        wdt_timeout,
    input  wire logic        core_sysreset_req,
    input  wire logic        foreign_write,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             core_reset_n,
    output logic             pins_logic_reset_n,
    output logic             analog_reset_n,
    output logic             fixed_pins_reset_n,
    output logic             wdt_load_default,
    output logic      [31:0] wdt_default_count
);
    import rsc_pkg::*;

    // Address decode, used by both read and write paths
    function automatic rsc_sel_e rsc_decode(input logic [31:0] addr);
        case (addr)
            `RSC_CFG_ADDR: rsc_decode = RSC_SEL_CFG;
            `RSC_KEY_ADDR: rsc_decode = RSC_SEL_KEY;
            `RSC_STA_ADDR: rsc_decode = RSC_SEL_STA;
            default:       rsc_decode = RSC_SEL_NONE;
        endcase
    endfunction

    rsc_sel_e    sel;        // Decoded register
    logic        wr_any;     // Access-phase write
    logic        wr_cfg;     // Write to configuration
    logic        wr_key;     // Write to key
    logic        wr_sta;     // Write to status
    logic        wr_other;   // Any other peripheral write
    logic        pin_evt;    // Reset pin asserted
    logic        wdt_evt;    // Watchdog timeout
    logic        soft_evt;   // Processor system reset
    logic        any_evt;    // Any non-power-on source
    logic        busy;       // Reset pulse active
    rsc_word_t   wdata;      // Low half of write data
    rsc_word_t   set_mask;   // Status bits set this cycle

    rsc_word_t   cfg_reg, cfg_next;
    rsc_word_t   key_reg, key_next;
    rsc_word_t   sta_reg, sta_next;
    rsc_lock_e   lock_reg, lock_next;
    logic        full_reg, full_next;   // Current pulse is a full reset
    logic [31:0] rdata_reg, rdata_next;
    logic [4:0]  out_reg, out_next;     // Registered reset fans

    // Bus strobes
    assign sel      = rsc_decode(paddr);
    assign wdata    = pwdata[15:0];
    assign wr_any   = psel & penable & pwrite;
    assign wr_cfg   = wr_any & (sel == RSC_SEL_CFG);
    assign wr_key   = wr_any & (sel == RSC_SEL_KEY);
    assign wr_sta   = wr_any & (sel == RSC_SEL_STA);
    assign wr_other = wr_sta | foreign_write |
                      (wr_any & (sel == RSC_SEL_NONE));
    // No wait states; unmapped addresses answer with an error
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & (sel == RSC_SEL_NONE);

    // software path arrives as the processor request pulse
    assign pin_evt  = ~ext_reset_pin_n;
    assign wdt_evt  = wdt_timeout;
    assign soft_evt = core_sysreset_req;
    assign any_evt  = pin_evt | wdt_evt | soft_evt;

    // Stretch each request into a clean reset pulse
    rsc_hold_timer u_hold (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .start   (any_evt),
        .busy    (busy)
    );

    // Status, key and configuration next values
    always_comb begin
        set_mask = `RSC_DATA_ZERO;
        set_mask[`RSC_STA_SOFT] = soft_evt;
        set_mask[`RSC_STA_WDT]  = wdt_evt;
        set_mask[`RSC_STA_PIN]  = pin_evt;
        // sticky, one clears; set beats clear in same cycle
        sta_next = sta_reg;
        if (wr_sta) begin
            sta_next = sta_reg & ~(wdata & `RSC_STA_WMASK);
        end
        sta_next = sta_next | set_mask;

        key_next  = key_reg;
        lock_next = lock_reg;
        cfg_next  = cfg_reg;
        if (any_evt) begin
            // every reset relocks and clears the key
            key_next  = `RSC_KEY_RESET;
            lock_next = RSC_LOCKED;
        end else if (wr_key) begin
            // key words must arrive in order
            key_next = wdata;
            if (wdata == `RSC_KEY_FIRST) begin
                lock_next = RSC_KEY_HALF;
            end else if (wdata == `RSC_KEY_SECOND &&
                         lock_reg == RSC_KEY_HALF) begin
                lock_next = RSC_UNLOCKED;
            end else begin
                lock_next = RSC_LOCKED;
            end
        end else if (wr_cfg) begin
            // only an unlocked write lands; either way relock
            if (lock_reg == RSC_UNLOCKED) begin
                cfg_next = wdata & `RSC_CFG_WMASK;
            end
            lock_next = RSC_LOCKED;
        end else if (wr_other) begin
            // any other write throws the key away
            lock_next = RSC_LOCKED;
        end
        // pin reset returns the configuration to defaults
        if (pin_evt) begin
            cfg_next = `RSC_CFG_RESET;
        end
    end

    // Pulse kind and reset fans
    always_comb begin
        // a pin event anywhere in the pulse makes it full
        if (pin_evt) begin
            full_next = 1'b1;
        end else if (any_evt && !busy) begin
            full_next = 1'b0;
        end else begin
            full_next = full_reg;
        end
        // Fans are active high here; all but the watchdog load are inverted at the ports
        out_next[0] = busy;
        // pins and logic retained only when bit is zero
        out_next[1] = busy & (full_reg | cfg_reg[`RSC_CFG_PINS]);
        // analog retained only when bit is zero
        out_next[2] = busy & (full_reg | cfg_reg[`RSC_CFG_ANALOG]);
        out_next[3] = busy;
        // watchdog reloads its defaults on every reset
        out_next[4] = busy;
    end

    // Read data captured in the setup phase, stable in access
    always_comb begin
        rdata_next = rdata_reg;
        if (psel && !penable && !pwrite) begin
            case (sel)
                RSC_SEL_CFG: rdata_next = {16'h0000, cfg_reg};
                RSC_SEL_KEY: rdata_next = {16'h0000, key_reg};
                RSC_SEL_STA: rdata_next = {16'h0000, sta_reg};
                default:     rdata_next = 32'h00000000;
            endcase
        end
    end

    // State registers; power-on is the only asynchronous reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg   <= `RSC_CFG_RESET;
            key_reg   <= `RSC_KEY_RESET;
            // power-on flag set; only a status write of one clears it
            sta_reg   <= `RSC_STA_AFTER_POR;
            lock_reg  <= RSC_LOCKED;
            full_reg  <= 1'b1;
            rdata_reg <= 32'h00000000;
            out_reg   <= 5'h1F;
        end else begin
            cfg_reg   <= cfg_next;
            key_reg   <= key_next;
            sta_reg   <= sta_next;
            lock_reg  <= lock_next;
            full_reg  <= full_next;
            rdata_reg <= rdata_next;
            out_reg   <= out_next;
        end
    end

    assign prdata             = rdata_reg;
    assign core_reset_n       = ~out_reg[0];
    assign pins_logic_reset_n = ~out_reg[1];
    assign analog_reset_n     = ~out_reg[2];
    assign fixed_pins_reset_n = ~out_reg[3];
    assign wdt_load_default   = out_reg[4];
    // Constant load value; the watchdog counts it down itself
    assign wdt_default_count  = WDT_DEFAULT_CYCLES;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    locked_cfg_a: assert property (
        wr_cfg && lock_reg != RSC_UNLOCKED && !any_evt |=> $stable(cfg_reg))
        else $error("locked configuration write landed");
    // Bus writes come at least two cycles apart, so check each step
    unlock_cfg_a: assert property (
        wr_cfg && lock_reg == RSC_UNLOCKED && !any_evt
        |=> cfg_reg == ($past(wdata) & `RSC_CFG_WMASK))
        else $error("unlocked configuration write lost");
    key_order_a: assert property (
        wr_key && wdata == `RSC_KEY_SECOND && lock_reg != RSC_KEY_HALF
        |=> lock_reg != RSC_UNLOCKED)
        else $error("second key word unlocked out of order");
    relock_other_a: assert property (
        lock_reg == RSC_UNLOCKED && wr_other |=> lock_reg == RSC_LOCKED)
        else $error("key not relocked by other write");
    soft_flag_a: assert property (
        soft_evt |=> sta_reg[`RSC_STA_SOFT])
        else $error("software reset flag not set");
    wdt_flag_a: assert property (
        wdt_evt |=> sta_reg[`RSC_STA_WDT])
        else $error("watchdog reset flag not set");
    pin_flag_a: assert property (
        pin_evt |=> sta_reg[`RSC_STA_PIN])
        else $error("pin reset flag not set");
    sticky_status_a: assert property (
        !wr_sta |=> ($past(sta_reg) & ~sta_reg) == `RSC_DATA_ZERO)
        else $error("status bit dropped without a write");
    fixed_pins_a: assert property (
        any_evt |-> ##2 !fixed_pins_reset_n [*2])
        else $error("fixed pins not reset");
    full_reset_a: assert property (
        pin_evt |-> ##2 (!pins_logic_reset_n && !analog_reset_n))
        else $error("pin reset left blocks retained");
    keep_pins_a: assert property (
        !busy && (soft_evt || wdt_evt) && !pin_evt && !wr_cfg &&
        !cfg_reg[`RSC_CFG_PINS] |-> ##2 pins_logic_reset_n)
        else $error("retained pins were reset");
    keep_analog_a: assert property (
        !busy && (soft_evt || wdt_evt) && !pin_evt && !wr_cfg &&
        !cfg_reg[`RSC_CFG_ANALOG] |-> ##2 analog_reset_n)
        else $error("retained analog was reset");
    wdt_default_a: assert property (
        any_evt |-> ##2 (wdt_load_default && !core_reset_n))
        else $error("watchdog defaults not loaded");
    lock_on_reset_a: assert property (
        any_evt |=> lock_reg == RSC_LOCKED && key_reg == `RSC_KEY_RESET)
        else $error("reset left key unlocked");

    soft_reset_c: cover property (soft_evt ##2 !core_reset_n);
    unlock_c: cover property (
        lock_reg == RSC_UNLOCKED ##1 lock_reg == RSC_LOCKED);
    w1c_c: cover property (wr_sta && sta_reg != `RSC_DATA_ZERO);
    retain_c: cover property (!core_reset_n && pins_logic_reset_n);
endmodule

//--- sim/rsc_cpu_model.sv
// Purpose: Processor software model driving the peripheral bus.
// Assumes: Inputs change on the falling clock edge, held until ready.
// Notes:   Also raises the core system reset request and foreign writes.
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] paddr,
    output logic      [31:0] pwdata,
    output logic             core_sysreset_req,
    output logic             foreign_write
);
    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        core_sysreset_req = 1'b0;
        foreign_write = 1'b0;
    end

    // Setup then access phase; answer taken at the ready edge
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        @(negedge sys_clk);
        psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge sys_clk);
        penable = 1'b1;
        // Bounded wait so a stuck ready cannot hang us
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        @(negedge sys_clk);
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
    endtask

    // Software store; the core's own reset register never hits the bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        if (a === `RSC_SYSRESET_ADDR) begin
            if (d === `RSC_SYSRESET_WORD) begin
                @(negedge sys_clk);
                core_sysreset_req = 1'b1;
                @(negedge sys_clk);
                core_sysreset_req = 1'b0;
            end
        end else begin
            xfer(1'b1, a, d, q, e);
        end
    endtask

    // Store to some other peripheral on the same bus
    task automatic other_write();
        @(negedge sys_clk);
        foreign_write = 1'b1;
        @(negedge sys_clk);
        foreign_write = 1'b0;
    endtask
endmodule

//--- sim/reset_source_control_tb.sv
// Purpose: Self-checking bench for the reset source controller.
// Assumes: 25 MHz clock, inputs driven on the falling edge.
// Notes:   Watchdog count shortened to 100 cycles.
`timescale 1ns/1ps
`include "rsc_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %0t mismatch got %h exp %h", $time, (a), (e)); end end
module reset_source_control_tb;
    logic        sys_clk, reset_n, ext_reset_pin_n, wdt_timeout;
    logic        core_sysreset_req, foreign_write, psel, penable, pwrite;
    logic [31:0] paddr, pwdata, prdata, wdt_default_count, q;
    logic        pready, pslverr, core_reset_n, pins_logic_reset_n;
    logic        analog_reset_n, fixed_pins_reset_n, wdt_load_default, e;
    logic [5:0]  seen;
    int          miscompares = 0;
    int          checked = 0;

    rsc_reset_ctrl #(.WDT_DEFAULT_CYCLES(32'h00000064)) uut (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .ext_reset_pin_n(ext_reset_pin_n), .wdt_timeout(wdt_timeout),
        .core_sysreset_req(core_sysreset_req),
        .foreign_write(foreign_write), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_reset_n(core_reset_n),
        .pins_logic_reset_n(pins_logic_reset_n),
        .analog_reset_n(analog_reset_n),
        .fixed_pins_reset_n(fixed_pins_reset_n),
        .wdt_load_default(wdt_load_default),
        .wdt_default_count(wdt_default_count));

    rsc_cpu_model cpu (
        .sys_clk(sys_clk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata),
        .core_sysreset_req(core_sysreset_req),
        .foreign_write(foreign_write));

    // Free-running 40 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Verdict printed once, from here only
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard, far beyond the expected run of about 300 cycles
    initial begin
        #(40 * 8000);
        miscompares++;
        give_verdict();
    end

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        logic err;
        cpu.xfer(1'b0, a, 32'h00000000, d, err);
    endtask

    // Key words then configuration write
    task automatic unlock_cfg(input logic [31:0] d);
        cpu.wr(`RSC_KEY_ADDR, 32'h00002009);
        cpu.wr(`RSC_KEY_ADDR, 32'h00000426);
        cpu.wr(`RSC_CFG_ADDR, d);
    endtask

    // Records which outputs asserted; bit 5 set once the pulse ended
    task automatic watch_pulse(output logic [5:0] s);
        int   n;
        logic went;
        s = 6'h00;
        went = 1'b0;
        for (n = 0; n < 80; n++) begin
            @(posedge sys_clk);
            #1;
            s[4:0] |= {~core_reset_n, ~pins_logic_reset_n, ~analog_reset_n,
                       ~fixed_pins_reset_n, wdt_load_default};
            if (core_reset_n === 1'b0) went = 1'b1;
            else if (went) break;
        end
        s[5] = went & core_reset_n;
    endtask

    task automatic t_power_on();
        watch_pulse(seen);
        `CHK(seen, 6'h3F)
        rd(`RSC_CFG_ADDR, q);
        `CHK(q, 32'h0000000F)
        rd(`RSC_KEY_ADDR, q);
        `CHK(q, 32'h00000000)
        rd(`RSC_STA_ADDR, q);
        `CHK(q, 32'h00000001)
        `CHK(wdt_default_count, 32'h00000064)
        cpu.xfer(1'b0, 32'h40005010, 32'h00000000, q, e);
        `CHK(e, 1'b1)
        `CHK(pready, 1'b1)
        $display("test power_on done");
    endtask

    task automatic t_clear_and_key();
        cpu.wr(`RSC_STA_ADDR, 32'h00000000);
        rd(`RSC_STA_ADDR, q);
        `CHK(q, 32'h00000001)
        cpu.wr(`RSC_STA_ADDR, 32'h00000001);
        rd(`RSC_STA_ADDR, q);
        `CHK(q, 32'h00000000)
        cpu.wr(`RSC_CFG_ADDR, 32'h00000000);
        rd(`RSC_CFG_ADDR, q);
        `CHK(q, 32'h0000000F)
        // Second key word alone must not unlock
        cpu.wr(`RSC_KEY_ADDR, 32'h00000426);
        cpu.wr(`RSC_CFG_ADDR, 32'h00000000);
        rd(`RSC_CFG_ADDR, q);
        `CHK(q, 32'h0000000F)
        cpu.wr(`RSC_KEY_ADDR, 32'h00002009);
        cpu.wr(`RSC_KEY_ADDR, 32'h00000426);
        cpu.other_write();
        cpu.wr(`RSC_CFG_ADDR, 32'h00000000);
        rd(`RSC_CFG_ADDR, q);
        `CHK(q, 32'h0000000F)
        unlock_cfg(32'h0000FFF0);
        rd(`RSC_CFG_ADDR, q);
        `CHK(q, 32'h00000000)
        $display("test clear_and_key done");
    endtask

    task automatic t_soft();
        // Full key entered before the reset must be void after it
        cpu.wr(`RSC_KEY_ADDR, 32'h00002009);
        cpu.wr(`RSC_KEY_ADDR, 32'h00000426);
        cpu.wr(`RSC_SYSRESET_ADDR, `RSC_SYSRESET_WORD);
        watch_pulse(seen);
        `CHK(seen, 6'h33)
        rd(`RSC_STA_ADDR, q);
        `CHK(q, 32'h00000008)
        rd(`RSC_KEY_ADDR, q);
        `CHK(q, 32'h00000000)
        cpu.wr(`RSC_CFG_ADDR, 32'h0000000F);
        rd(`RSC_CFG_ADDR, q);
        `CHK(q, 32'h00000000)
        cpu.wr(`RSC_STA_ADDR, 32'h00000008);
        $display("test soft done");
    endtask

    task automatic t_watchdog_pin();
        unlock_cfg(32'h00000008);
        @(negedge sys_clk) wdt_timeout = 1'b1;
        @(negedge sys_clk) wdt_timeout = 1'b0;
        watch_pulse(seen);
        `CHK(seen, 6'h37)
        rd(`RSC_STA_ADDR, q);
        `CHK(q, 32'h00000004)
        @(negedge sys_clk) ext_reset_pin_n = 1'b0;
        @(negedge sys_clk) ext_reset_pin_n = 1'b1;
        watch_pulse(seen);
        `CHK(seen, 6'h3F)
        rd(`RSC_STA_ADDR, q);
        `CHK(q, 32'h00000006)
        rd(`RSC_CFG_ADDR, q);
        `CHK(q, 32'h0000000F)
        cpu.wr(`RSC_STA_ADDR, 32'h00000006);
        rd(`RSC_STA_ADDR, q);
        `CHK(q, 32'h00000000)
        $display("test watchdog_pin done");
    endtask

    task automatic t_second_por();
        unlock_cfg(32'h00000000);
        @(negedge sys_clk) reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        t_power_on();
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        ext_reset_pin_n = 1'b1;
        wdt_timeout = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        t_power_on();
        t_clear_and_key();
        t_soft();
        t_watchdog_pin();
        t_second_por();
        give_verdict();
    end
endmodule
